/* src/otu_pkg.sv */
// constants, types and lookup functions of the oscillator training unit
package otu_pkg;

	// clock and measurement window
	localparam int unsigned CLK_MHZ         = 100;
	localparam int unsigned WINDOW_US       = 4000;
	localparam int unsigned NOMINAL_CYCLES  = WINDOW_US * CLK_MHZ;
	localparam int unsigned PERIOD_MIN_US   = 500;
	localparam int unsigned PERIOD_MAX_US   = 4000;

	// measurement acceptance window and trim deadband, in cycles of the measured clock
	localparam int unsigned WINDOW_CYCLES   = 8000;
	localparam int unsigned DEADBAND_CYCLES = 400;

	// post-reset delay before training may start in the sync pulse mode
	localparam int unsigned POST_RESET_DELAY_US = 1000;
	localparam int unsigned POST_RESET_CYCLES   = POST_RESET_DELAY_US * CLK_MHZ;

	// widths
	localparam int unsigned CYC_W   = 20;
	localparam int unsigned DLY_W   = 24;
	localparam int unsigned PER_W   = 4;
	localparam int unsigned US_W    = 13;
	localparam int unsigned TRIM_W  = 8;
	localparam int unsigned ERRC_W  = 7;

	// trim register
	localparam logic [TRIM_W-1:0] TRIM_FACTORY = 8'h80;
	localparam logic [TRIM_W-1:0] TRIM_STEP    = 8'h01;
	localparam logic [TRIM_W-1:0] TRIM_MAX     = 8'hFF;
	localparam logic [TRIM_W-1:0] TRIM_MIN     = 8'h00;

	// error filter saturation
	localparam logic [ERRC_W-1:0] ERRC_MAX = 7'h7F;
	localparam logic [ERRC_W-1:0] ERRC_MIN = 7'h00;

	typedef enum logic [1:0] {
		OTU_MODE_SPI  = 2'b00,
		OTU_MODE_I2C  = 2'b01,
		OTU_MODE_PSI5 = 2'b10,
		OTU_MODE_DSI3 = 2'b11
	} otu_mode_t;

	typedef enum logic [1:0] {
		OTU_ST_IDLE    = 2'b00,
		OTU_ST_FIRST   = 2'b01,
		OTU_ST_MEASURE = 2'b10
	} otu_state_t;

	// periodic command period field to period in microseconds
	function automatic logic [US_W-1:0] otu_pdcm_us(input logic [2:0] code);
		logic [US_W-1:0] us;
		case (code)
			3'h0:    us = 13'h01F4;
			3'h1:    us = 13'h03E8;
			3'h2:    us = 13'h07D0;
			3'h3:    us = 13'h0FA0;
			3'h4:    us = 13'h00FA;
			3'h5:    us = 13'h0320;
			3'h6:    us = 13'h0BB8;
			default: us = 13'h1388;
		endcase
		return us;
	endfunction : otu_pdcm_us

	// command-response period field to period in microseconds
	function automatic logic [US_W-1:0] otu_crm_us(input logic [1:0] code);
		logic [US_W-1:0] us;
		case (code)
			2'h0:    us = 13'h01F4;
			2'h1:    us = 13'h03E8;
			2'h2:    us = 13'h07D0;
			default: us = 13'h0FA0;
		endcase
		return us;
	endfunction : otu_crm_us

endpackage : otu_pkg

/* src/otu_err_filter.sv */
// saturating up/down error filter with threshold compare
`timescale 1ns/1ps

module otu_err_filter
	import otu_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              step_up,
	input  wire logic              step_down,
	input  wire logic [ERRC_W-1:0] threshold,
	output logic      [ERRC_W-1:0] count,
	output logic                   hit
);

	typedef struct packed {
		logic [ERRC_W-1:0] cnt;
	} otu_filt_t;

	otu_filt_t f_reg;
	otu_filt_t f_next;

	always_comb begin
		f_next = f_reg;
		if (step_up && f_reg.cnt != ERRC_MAX) begin
			f_next.cnt = f_reg.cnt + 7'h01;
		end else if (step_down && f_reg.cnt != ERRC_MIN) begin
			f_next.cnt = f_reg.cnt - 7'h01;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			f_reg <= '0;
		end else begin
			f_reg <= f_next;
		end
	end

	assign count = f_reg.cnt;
	// a zero threshold disables the hit output instead of flagging at once; the count still moves
	assign hit   = (threshold != ERRC_MIN) && (f_reg.cnt >= threshold);

endmodule : otu_err_filter

/* src/otu_train.sv */
// oscillator training unit: window measurement, trim stepping and error flag
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - training runs only while the enable bit is set, timed by master traffic.
// - periods per 4 ms window are computed from the programmed period.
// - while enabled with a legal period, each window opened by a reference event completes a measurement.
// - own clock cycles are counted across the computed number of periods.
// - trim adjusts only if the measurement lies in the training window.
// - count above nominal plus deadband lowers the trim by one step.
// - count below nominal minus deadband raises the trim by one step.
// - in PSI5 with training on, sync pulses get no answer in phase one.
// - in PSI5, training starts a fixed delay after reset.
// - enabled training that cannot complete sets the training error flag.
// - each in/out window result passes through an up/down counter.
// - out-of-window measurement increments the error counter.
// - in-window measurement decrements the error counter.
// - error flag sets when the counter reaches a nonzero programmed threshold.
// - error counter saturates at 127 and at 0.
// - derived period outside 500 us to 4 ms raises the training error.
// - derived period not dividing 4 ms evenly raises the training error.
// - disabling after start with revert clear keeps the last trim.
// - disabling after start with revert set restores the factory trim.
module otu_train
	import otu_pkg::*;
#(
	parameter int unsigned NOMINAL_CYC    = NOMINAL_CYCLES,
	parameter int unsigned POST_RESET_CYC = POST_RESET_CYCLES
)
(
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              training_enable_bit,
	input  wire logic              training_revert_bit,
	input  wire logic [1:0]        mode_sel,
	input  wire logic              crm_active,
	input  wire logic [2:0]        periodic_command_period_field,
	input  wire logic [1:0]        cmd_response_period_field,
	input  wire logic [ERRC_W-1:0] training_error_threshold,
	input  wire logic              ref_event,
	input  wire logic              psi5_phase1,
	input  wire logic              error_clear,
	output logic      [TRIM_W-1:0] trim_target,
	output logic                   training_error_flag,
	output logic                   sync_response_block,
	output logic      [CYC_W-1:0]  measured_cycle_count,
	output logic                   measure_done,
	output logic                   training_active,
	output logic      [ERRC_W-1:0] error_count
);

	////////////////////////////////////////////////////////////////////////////
	// derived constants

	localparam logic [CYC_W-1:0] NOM_C   = CYC_W'(NOMINAL_CYC);
	localparam logic [CYC_W-1:0] WIN_C   = CYC_W'(WINDOW_CYCLES);
	localparam logic [CYC_W-1:0] ADJ_C   = CYC_W'(DEADBAND_CYCLES);
	localparam logic [CYC_W-1:0] LIM_HI  = NOM_C + WIN_C;
	// a nominal count below the window clamps the lower limit instead of wrapping
	localparam logic [CYC_W-1:0] LIM_LO  = (NOM_C > WIN_C) ? NOM_C - WIN_C : '0;
	localparam logic [CYC_W-1:0] ADJ_HI  = NOM_C + ADJ_C;
	localparam logic [CYC_W-1:0] ADJ_LO  = (NOM_C > ADJ_C) ? NOM_C - ADJ_C : '0;
	localparam logic [DLY_W-1:0] DLY_END = DLY_W'(POST_RESET_CYC);
	localparam logic [US_W-1:0]  WIN_US  = US_W'(WINDOW_US);
	localparam logic [US_W-1:0]  PMIN_US = US_W'(PERIOD_MIN_US);
	localparam logic [US_W-1:0]  PMAX_US = US_W'(PERIOD_MAX_US);

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		otu_state_t        st;
		logic [CYC_W-1:0]  cyc;
		logic [PER_W-1:0]  per;
		logic [CYC_W-1:0]  meas;
		logic              done;
		logic [TRIM_W-1:0] trim;
		logic              err;
		logic              started;
		logic              en_d;
		logic [DLY_W-1:0]  dly;
		logic              dly_ok;
	} otu_core_t;

	otu_core_t r_reg;
	otu_core_t r_next;

	////////////////////////////////////////////////////////////////////////////
	// configuration checks

	logic [US_W-1:0]  period_us;
	logic [US_W-1:0]  n_per_full;
	logic [US_W-1:0]  per_rem;
	logic [PER_W-1:0] n_per;
	logic             cfg_bad;
	logic             mode_psi5;
	logic             run;

	always_comb begin
		period_us = crm_active ? otu_crm_us(cmd_response_period_field)
		                       : otu_pdcm_us(periodic_command_period_field);
		// guarded divide: a zero period never reaches the divider
		n_per_full = (period_us == '0) ? '0 : (WIN_US / period_us);
		per_rem    = (period_us == '0) ? '0 : (WIN_US % period_us);
		n_per      = n_per_full[PER_W-1:0];
	end

	assign cfg_bad = (period_us < PMIN_US) || (period_us > PMAX_US)
	               || (per_rem != '0);
	assign mode_psi5 = (mode_sel == OTU_MODE_PSI5);
	// training is held off in PSI5 until the post-reset delay ends
	assign run = training_enable_bit && !cfg_bad && (!mode_psi5 || r_reg.dly_ok);

	////////////////////////////////////////////////////////////////////////////
	// measurement end and evaluation

	logic [CYC_W-1:0] cyc_inc;
	logic             last_event;
	logic             timeout;
	logic             finish;
	logic [CYC_W-1:0] meas_val;
	logic             in_win;
	logic             res_in;
	logic             res_out;

	assign cyc_inc    = r_reg.cyc + 20'h0_0001;
	assign last_event = ref_event && ((r_reg.per + 4'h1) == n_per);
	// a missing reference event must not stall the window forever
	assign timeout    = (cyc_inc > LIM_HI) && !last_event;
	assign finish     = run && (r_reg.st == OTU_ST_MEASURE) && (last_event || timeout);
	assign meas_val   = cyc_inc;
	assign in_win     = !timeout && (meas_val >= LIM_LO) && (meas_val <= LIM_HI);
	assign res_in     = finish && in_win;
	assign res_out    = finish && !in_win;

	////////////////////////////////////////////////////////////////////////////
	// error filter

	logic filt_hit;

	otu_err_filter u_filt (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.step_up   (res_out),
		.step_down (res_in),
		.threshold (training_error_threshold),
		.count     (error_count),
		.hit       (filt_hit)
	);

	////////////////////////////////////////////////////////////////////////////
	// next state

	logic err_set;

	assign err_set = training_enable_bit && (cfg_bad || filt_hit);

	always_comb begin
		r_next      = r_reg;
		r_next.done = 1'b0;
		r_next.en_d = training_enable_bit;

		if (r_reg.dly != DLY_END) begin
			r_next.dly = r_reg.dly + 24'h00_0001;
		end
		r_next.dly_ok = (r_reg.dly == DLY_END);

		case (r_reg.st)
			OTU_ST_IDLE: begin
				r_next.cyc = '0;
				r_next.per = '0;
				if (run) begin
					r_next.st = OTU_ST_FIRST;
				end
			end
			OTU_ST_FIRST: begin
				if (!run) begin
					r_next.st = OTU_ST_IDLE;
				end else if (ref_event) begin
					r_next.st      = OTU_ST_MEASURE;
					r_next.cyc     = '0;
					r_next.per     = '0;
					r_next.started = 1'b1;
				end
			end
			OTU_ST_MEASURE: begin
				if (!run) begin
					r_next.st = OTU_ST_IDLE;
				end else if (finish) begin
					r_next.meas = meas_val;
					r_next.done = 1'b1;
					r_next.cyc  = '0;
					r_next.per  = '0;
					// the closing event opens the next window back to back
					if (timeout) begin
						r_next.st = OTU_ST_FIRST;
					end
					if (in_win) begin
						if (meas_val > ADJ_HI) begin
							if (r_reg.trim >= TRIM_MIN + TRIM_STEP) begin
								r_next.trim = r_reg.trim - TRIM_STEP;
							end else begin
								r_next.trim = TRIM_MIN;
							end
						end else if (meas_val < ADJ_LO) begin
							if (r_reg.trim <= TRIM_MAX - TRIM_STEP) begin
								r_next.trim = r_reg.trim + TRIM_STEP;
							end else begin
								r_next.trim = TRIM_MAX;
							end
						end
					end
				end else begin
					r_next.cyc = cyc_inc;
					if (ref_event) begin
						r_next.per = r_reg.per + 4'h1;
					end
				end
			end
			default: begin
				r_next.st = OTU_ST_IDLE;
			end
		endcase

		// falling enable after a start: keep trim unless revert asked
		if (r_reg.en_d && !training_enable_bit && r_reg.started) begin
			r_next.started = 1'b0;
			if (training_revert_bit) begin
				r_next.trim = TRIM_FACTORY;
			end
			// revert clear: trim simply left as is
		end

		// set wins over a clear arriving in the same cycle
		if (err_set) begin
			r_next.err = 1'b1;
		end else if (error_clear) begin
			r_next.err = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			r_reg.st      <= OTU_ST_IDLE;
			r_reg.cyc     <= '0;
			r_reg.per     <= '0;
			r_reg.meas    <= '0;
			r_reg.done    <= 1'b0;
			r_reg.trim    <= TRIM_FACTORY;
			r_reg.err     <= 1'b0;
			r_reg.started <= 1'b0;
			r_reg.en_d    <= 1'b0;
			r_reg.dly     <= '0;
			r_reg.dly_ok  <= 1'b0;
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign trim_target          = r_reg.trim;
	assign training_error_flag  = r_reg.err;
	assign measured_cycle_count = r_reg.meas;
	assign measure_done         = r_reg.done;
	assign training_active      = (r_reg.st != OTU_ST_IDLE);
	// phase-one sync pulses go unanswered so training completes first
	assign sync_response_block  = training_enable_bit && mode_psi5 && psi5_phase1;

endmodule : otu_train

/* bench/otu_train_checker.sv */
// assertion checker for the oscillator training unit
`timescale 1ns/1ps

module otu_train_checker
	import otu_pkg::*;
#(
	parameter int unsigned NOMINAL_CYC = NOMINAL_CYCLES
)
(
	input wire logic              clk_sys,
	input wire logic              rst,
	input wire logic              training_enable_bit,
	input wire logic [1:0]        mode_sel,
	input wire logic              crm_active,
	input wire logic [2:0]        periodic_command_period_field,
	input wire logic [ERRC_W-1:0] training_error_threshold,
	input wire logic              psi5_phase1,
	input wire logic              error_clear,
	input wire logic [TRIM_W-1:0] trim_target,
	input wire logic              training_error_flag,
	input wire logic              sync_response_block,
	input wire logic [CYC_W-1:0]  measured_cycle_count,
	input wire logic              measure_done,
	input wire logic              training_active,
	input wire logic [ERRC_W-1:0] error_count
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	int   m;
	logic inw;
	assign m = int'(measured_cycle_count);
	// written without subtraction so a small nominal count cannot wrap
	assign inw = (m + WINDOW_CYCLES > NOMINAL_CYC) && (m < NOMINAL_CYC + WINDOW_CYCLES);

	a_trim_down: assert property (measure_done && inw && m > NOMINAL_CYC + DEADBAND_CYCLES
		&& $past(trim_target) != TRIM_MIN |-> trim_target == $past(trim_target) - TRIM_STEP)
		else $error("trim not lowered on long count");
	a_trim_up: assert property (measure_done && inw && m + DEADBAND_CYCLES < NOMINAL_CYC
		&& $past(trim_target) != TRIM_MAX |-> trim_target == $past(trim_target) + TRIM_STEP)
		else $error("trim not raised on short count");
	a_trim_dead: assert property (measure_done && m + DEADBAND_CYCLES >= NOMINAL_CYC
		&& m <= NOMINAL_CYC + DEADBAND_CYCLES |-> $stable(trim_target))
		else $error("trim moved inside deadband");
	a_trim_cause: assert property (training_enable_bit && !$stable(trim_target) |-> measure_done)
		else $error("trim moved without measurement");
	a_sync_block: assert property (sync_response_block == (training_enable_bit
		&& mode_sel == OTU_MODE_PSI5 && psi5_phase1))
		else $error("sync response block wrong");
	a_flag_sticky: assert property (training_error_flag && !error_clear |=> training_error_flag)
		else $error("error flag dropped");
	a_flag_hit: assert property (training_enable_bit && training_error_threshold != ERRC_MIN
		&& error_count >= training_error_threshold |-> ##[1:2] training_error_flag)
		else $error("threshold reached without flag");
	a_cfg_range: assert property (training_enable_bit && !crm_active
		&& periodic_command_period_field inside {3'h4, 3'h7} |=> training_error_flag)
		else $error("out of range period not flagged");
	a_cfg_divide: assert property (training_enable_bit && !crm_active
		&& periodic_command_period_field == 3'h6 |=> training_error_flag)
		else $error("non dividing period not flagged");
	a_count_step: assert property (!$stable(error_count) |-> measure_done || $past(measure_done))
		else $error("error count moved without measurement");
	a_idle_off: assert property (!training_enable_bit |=> !training_active)
		else $error("training active while disabled");
endmodule : otu_train_checker

bind otu_train otu_train_checker #(.NOMINAL_CYC(NOMINAL_CYC)) u_chk (.clk_sys(clk_sys), .rst(rst),
	.training_enable_bit(training_enable_bit), .mode_sel(mode_sel), .crm_active(crm_active),
	.periodic_command_period_field(periodic_command_period_field),
	.training_error_threshold(training_error_threshold), .psi5_phase1(psi5_phase1),
	.error_clear(error_clear), .trim_target(trim_target), .training_error_flag(training_error_flag),
	.sync_response_block(sync_response_block), .measured_cycle_count(measured_cycle_count),
	.measure_done(measure_done), .training_active(training_active), .error_count(error_count));

/* bench/otu_master_model.sv */
// periodic reference transfer source standing in for the bus master
`timescale 1ns/1ps

module otu_master_model (
	input  wire logic        clk_sys,
	input  wire logic        run,
	input  wire logic [15:0] gap,
	output logic             ref_event
);
	logic [15:0] cnt_reg;

	initial begin
		cnt_reg = 16'h0000;
		ref_event = 1'b0;
	end

	// a shrunk gap restarts at once rather than wrapping the counter
	// rising edge: run and gap from the bench have settled by then
	always @(posedge clk_sys) begin
		if (!run) begin
			cnt_reg <= 16'h0000;
			ref_event <= 1'b0;
		end else begin
			ref_event <= (cnt_reg == 16'h0000);
			cnt_reg <= (cnt_reg + 16'h0001 >= gap) ? 16'h0000 : cnt_reg + 16'h0001;
		end
	end
endmodule : otu_master_model

/* bench/otu_train_bench.sv */
// self-checking bench for the oscillator training unit
`timescale 1ns/1ps

module otu_train_bench
	import otu_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        en = 1'b0;
	logic        rev = 1'b0;
	logic        ph1 = 1'b0;
	logic        clr = 1'b0;
	logic        run = 1'b0;
	logic        crm = 1'b0;
	logic [1:0]  crmcode = 2'h2;
	logic [1:0]  mode = OTU_MODE_SPI;
	logic [2:0]  pcode = 3'h3;
	logic [6:0]  thr = 7'h02;
	logic [15:0] gap = 16'h0BB8;
	logic        ev;
	logic [7:0]  trim;
	logic        flag;
	logic        blk;
	logic [19:0] meas;
	logic        done;
	logic        act;
	logic [6:0]  errc;
	int          fail_count = 0;
	int          checks_done = 0;

	always #5 clk_sys = ~clk_sys;

	otu_master_model u_master (.clk_sys(clk_sys), .run(run), .gap(gap), .ref_event(ev));

	// short nominal count puts the nominal window at 2000 cycles
	otu_train #(.NOMINAL_CYC(2000), .POST_RESET_CYC(50)) dut (.clk_sys(clk_sys), .rst(rst),
		.training_enable_bit(en), .training_revert_bit(rev), .mode_sel(mode), .crm_active(crm),
		.periodic_command_period_field(pcode), .cmd_response_period_field(crmcode),
		.training_error_threshold(thr), .ref_event(ev), .psi5_phase1(ph1), .error_clear(clr),
		.trim_target(trim), .training_error_flag(flag), .sync_response_block(blk),
		.measured_cycle_count(meas), .measure_done(done), .training_active(act), .error_count(errc));

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	task automatic check_val(input string what, input logic [19:0] exp, input logic [19:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check_val

	task automatic wait_done(input int lim);
		for (int i = 0; i < lim; i++) begin
			@(negedge clk_sys);
			if (done === 1'b1)
				return;
		end
		fail_count++;
		$display("MISMATCH measure_done expected 1 seen 0");
		results();
	endtask : wait_done

	task automatic train(input logic [1:0] m, input logic [2:0] p, input logic [15:0] g);
		mode = m;
		pcode = p;
		gap = g;
		en = 1'b1;
		repeat (3) @(negedge clk_sys);
		run = 1'b1;
	endtask : train

	initial begin
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'b0;
		check_val("trim", 20'(TRIM_FACTORY), 20'(trim));
		check_val("flag", 20'h0_0000, 20'(flag));
		train(OTU_MODE_SPI, 3'h3, 16'h0BB8);
		wait_done(8000);
		check_val("measured", 20'h0_0BB8, meas);
		check_val("trim", 20'h0_007F, 20'(trim));
		repeat (2) @(negedge clk_sys);
		check_val("errcount", 20'h0_0000, 20'(errc));
		gap = 16'h03E8;
		wait_done(4000);
		check_val("trim", 20'h0_0080, 20'(trim));
		gap = 16'h0BB8;
		wait_done(4000);
		gap = 16'h07D0;
		wait_done(4000);
		check_val("trim", 20'h0_007F, 20'(trim));
		en = 1'b0;
		run = 1'b0;
		repeat (3) @(negedge clk_sys);
		check_val("trim", 20'h0_007F, 20'(trim));
		check_val("active", 20'h0_0000, 20'(act));
		train(OTU_MODE_I2C, 3'h2, 16'h03E8);
		wait_done(8000);
		check_val("measured", 20'h0_07D0, meas);
		gap = 16'h2EE0;
		wait_done(30000);
		check_val("trim", 20'h0_007F, 20'(trim));
		repeat (2) @(negedge clk_sys);
		check_val("errcount", 20'h0_0001, 20'(errc));
		wait_done(30000);
		repeat (2) @(negedge clk_sys);
		check_val("flag", 20'h0_0001, 20'(flag));
		gap = 16'h03E8;
		wait_done(30000);
		repeat (2) @(negedge clk_sys);
		check_val("errcount", 20'h0_0001, 20'(errc));
		check_val("flag", 20'h0_0001, 20'(flag));
		clr = 1'b1;
		@(negedge clk_sys);
		clr = 1'b0;
		check_val("flag", 20'h0_0000, 20'(flag));
		for (int c = 4; c < 8; c++) begin
			pcode = 3'(c);
			repeat (2) @(negedge clk_sys);
			// 800 us divides the window evenly, so that code stays legal
			check_val("flag", (c == 5) ? 20'h0_0000 : 20'h0_0001, 20'(flag));
			pcode = 3'h2;
			clr = 1'b1;
			@(negedge clk_sys);
			clr = 1'b0;
		end
		// command-response source selected: the bad periodic code is not used
		crm = 1'b1;
		pcode = 3'h4;
		repeat (2) @(negedge clk_sys);
		check_val("flag", 20'h0_0000, 20'(flag));
		crm = 1'b0;
		pcode = 3'h2;
		gap = 16'h0BB8;
		wait_done(20000);
		check_val("trim", 20'h0_007E, 20'(trim));
		en = 1'b0;
		rev = 1'b1;
		run = 1'b0;
		repeat (3) @(negedge clk_sys);
		check_val("trim", 20'h0_0080, 20'(trim));
		mode = OTU_MODE_PSI5;
		ph1 = 1'b1;
		en = 1'b1;
		@(negedge clk_sys);
		check_val("block", 20'h0_0001, 20'(blk));
		ph1 = 1'b0;
		@(negedge clk_sys);
		check_val("block", 20'h0_0000, 20'(blk));
		rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		repeat (40) @(negedge clk_sys);
		check_val("active", 20'h0_0000, 20'(act));
		repeat (20) @(negedge clk_sys);
		check_val("active", 20'h0_0001, 20'(act));
		results();
	end
endmodule : otu_train_bench
